// file: pkg/usart_host_defs.svh
// Purpose: named constants for the serial-controller host bridge
// Assumes: 20 MHz pclk, APB3 register bus with 32-bit data
// Notes: definitions only, no logic
`ifndef USART_HOST_DEFS_SVH
`define USART_HOST_DEFS_SVH

// ----------------------------------------
// timing of one device bus cycle
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define ADDR_SETUP_NS 50
`define STROBE_NS 250
`define ADDR_HOLD_NS 50

// ----------------------------------------
// own register map (byte addresses)
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_STATUS 12'h008
`define OFS_RDATA 12'h00C

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_RESET_BIT 0
`define CTRL_TX_EN_BIT 1
`define CTRL_RESET_VAL 2'h1
`define CMD_DATA_LSB 0
`define CMD_SEL_LSB 8
`define CMD_WRITE_BIT 10
`define ST_BUSY_BIT 0
`define ST_RX_WAIT_BIT 1
`define ST_TX_FREE_BIT 2
`define ST_EMPTY_CHG_BIT 3
`define ST_DEV_RESET_BIT 4
`define ST_TX_EN_BIT 5
`define CYC_ZERO 4'h0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h00000000

`endif

// file: pkg/usart_host_pkg.sv
// Purpose: types shared by the host bridge modules
// Assumes: usart_host_defs.svh on the include path
// Notes: cycle counts are derived here from nanosecond figures
`include "usart_host_defs.svh"

package usart_host_pkg;

	// ----------------------------------------
	// bus cycle sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SETUP = 2'h1,
		ST_STROBE = 2'h3,
		ST_HOLD = 2'h2
	} seq_state_t;

	// one access request to the device
	typedef struct packed {
		logic write;
		logic [1:0] sel;
		logic [7:0] data;
	} dev_req_t;

	// processor-side pins of the device, host view
	typedef struct packed {
		logic ce_n;
		logic rw;
		logic [1:0] sel;
		logic [7:0] dout;
		logic doe;
	} dev_pins_t;

	// least time to whole cycles, never below one
	function automatic logic [3:0] ns_to_cycles(input int ns);
		int c;
		c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
		if (c < 1) begin
			c = 1;
		end
		return c[3:0];
	endfunction

endpackage

// file: design/bus_cycle_seq.sv
// Purpose: runs one read or write cycle on the device's processor bus
// Assumes: start is a one-cycle pulse, only given while idle
// Notes: address and direction stay put from setup through hold
`timescale 1ns/1ps
`default_nettype none

module bus_cycle_seq (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic start, // begin a cycle, one-cycle pulse
	input wire usart_host_pkg::dev_req_t req, // access to perform
	input wire logic [7:0] din, // device data bus as seen by host
	output usart_host_pkg::dev_pins_t pins, // registered pin drive
	output logic busy, // cycle in progress
	output logic done, // cycle finished, one-cycle pulse
	output logic [7:0] rdata // byte captured on a read
);
	import usart_host_pkg::*;

	localparam logic [3:0] SETUP_CYC = ns_to_cycles(`ADDR_SETUP_NS);
	localparam logic [3:0] STROBE_CYC = ns_to_cycles(`STROBE_NS);
	localparam logic [3:0] HOLD_CYC = ns_to_cycles(`ADDR_HOLD_NS);

	seq_state_t state_reg;
	logic [3:0] cnt_reg;
	dev_pins_t pins_reg;
	logic done_reg;
	logic [7:0] rdata_reg;
	logic last;

	assign last = (cnt_reg == `CYC_ZERO);

	// ----------------------------------------
	// state and cycle counter
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= `CYC_ZERO;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_SETUP;
						cnt_reg <= SETUP_CYC - 4'h1;
					end
				end
				ST_SETUP: begin
					if (last) begin
						state_reg <= ST_STROBE;
						cnt_reg <= STROBE_CYC - 4'h1;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				ST_STROBE: begin
					if (last) begin
						state_reg <= ST_HOLD;
						cnt_reg <= HOLD_CYC - 4'h1;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				ST_HOLD: begin
					if (last) begin
						state_reg <= ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// select and direction latch at start and never move while enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_reg.ce_n <= 1'b1;
			pins_reg.rw <= 1'b0;
			pins_reg.sel <= 2'h0;
			pins_reg.dout <= `BYTE_ZERO;
			pins_reg.doe <= 1'b0;
		end else begin
			if (state_reg == ST_IDLE && start) begin
				pins_reg.rw <= req.write;
				pins_reg.sel <= req.sel;
				pins_reg.dout <= req.data;
				pins_reg.doe <= req.write; // drive only on writes
			end
			if (state_reg == ST_SETUP && last) begin
				pins_reg.ce_n <= 1'b0;
			end
			if (state_reg == ST_STROBE && last) begin
				pins_reg.ce_n <= 1'b1;
			end
			if (state_reg == ST_HOLD && last) begin
				pins_reg.doe <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read capture and completion
	// ----------------------------------------
	// sample at the end of the strobe, when the device data has settled longest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= `BYTE_ZERO;
			done_reg <= 1'b0;
		end else begin
			if (state_reg == ST_STROBE && last && !pins_reg.rw) begin
				rdata_reg <= din;
			end
			done_reg <= (state_reg == ST_HOLD) && last;
		end
	end

	assign pins = pins_reg;
	assign busy = (state_reg != ST_IDLE);
	assign done = done_reg;
	assign rdata = rdata_reg;

endmodule

`default_nettype wire

// file: design/usart_host_ctrl.sv
// Purpose: APB-controlled host that drives a serial controller's processor bus
// Assumes: device inputs synchronous to pclk; pull-ups outside the block
// Notes: one device access per command write; refused commands are dropped
//
// Behaviour
// - device acts only while chip enable is low; otherwise its bus floats
// - direction low reads, high writes; ignored while chip enable is high
// - two select lines with direction choose the device register
// - host honours transmit-ready only while the transmitter is enabled
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module usart_host_ctrl (
	input wire logic pclk, // system clock, 20 MHz
	input wire logic presetn, // async reset, active low
	input wire logic [11:0] paddr, // APB byte address
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high writes
	input wire logic [31:0] pwdata, // APB write data
	output logic pready, // APB ready
	output logic [31:0] prdata, // APB read data
	output logic pslverr, // APB error, unmapped address
	output logic dev_ce_n, // device chip enable, active low
	output logic dev_rw, // device direction, high writes
	output logic [1:0] dev_sel, // device register select
	output logic [7:0] dev_data_out, // data driven toward device
	output logic dev_data_oe, // high while host drives data
	input wire logic [7:0] dev_data_in, // data bus level
	output logic dev_reset, // device master reset, active high
	input wire logic rx_char_waiting_n, // receive-ready, active low
	input wire logic tx_holding_free_n, // transmit-ready, active low
	input wire logic tx_empty_or_modem_change_n // empty/change, active low
);
	import usart_host_pkg::*;

	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [1:0] ctrl_reg;
	dev_req_t req_reg;
	logic start_reg;
	logic [7:0] rdata_reg;
	logic rx_n_reg;
	logic tx_n_reg;
	logic emc_n_reg;
	logic seq_busy;
	logic seq_done;
	logic [7:0] seq_rdata;
	dev_pins_t seq_pins;
	logic access;
	logic commit;
	logic cmd_ok;
	logic mapped;
	logic [31:0] status_word;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// first access cycle computes the answer, second one commits with pready high
	assign access = psel && penable && !pready_reg;
	assign commit = psel && penable && pready_reg && pwrite;
	assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_CMD) ||
		(paddr == `OFS_STATUS) || (paddr == `OFS_RDATA);
	// commands are taken only when the device is out of reset and the bus is free
	assign cmd_ok = !ctrl_reg[`CTRL_RESET_BIT] && !seq_busy && !start_reg;

	// status word, ready indications inverted to active high
	always_comb begin
		status_word = `WORD_ZERO;
		status_word[`ST_BUSY_BIT] = seq_busy || start_reg;
		status_word[`ST_RX_WAIT_BIT] = !rx_n_reg;
		// transmit-ready means nothing while the transmitter is off
		status_word[`ST_TX_FREE_BIT] = !tx_n_reg && ctrl_reg[`CTRL_TX_EN_BIT];
		status_word[`ST_EMPTY_CHG_BIT] = !emc_n_reg;
		status_word[`ST_DEV_RESET_BIT] = ctrl_reg[`CTRL_RESET_BIT];
		status_word[`ST_TX_EN_BIT] = ctrl_reg[`CTRL_TX_EN_BIT];
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= `WORD_ZERO;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= access;
			// error stands with pready only, never into the idle cycle after it
			pslverr_reg <= access && !mapped;
			if (access) begin
				prdata_reg <= `WORD_ZERO;
				if (!pwrite) begin
					unique case (1'b1)
						(paddr == `OFS_CTRL): prdata_reg <= {30'h0, ctrl_reg};
						(paddr == `OFS_STATUS): prdata_reg <= status_word;
						(paddr == `OFS_RDATA): prdata_reg <= {24'h0, rdata_reg};
						default: prdata_reg <= `WORD_ZERO;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// device reset comes up asserted so the device starts cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET_VAL;
		end else if (commit && paddr == `OFS_CTRL) begin
			ctrl_reg[`CTRL_RESET_BIT] <= pwdata[`CTRL_RESET_BIT];
			ctrl_reg[`CTRL_TX_EN_BIT] <= pwdata[`CTRL_TX_EN_BIT];
		end
	end

	// ----------------------------------------
	// command launch
	// ----------------------------------------
	// a command arriving while busy or in reset is dropped, not queued
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_reg <= '0;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (commit && paddr == `OFS_CMD && cmd_ok) begin
				req_reg.data <= pwdata[`CMD_DATA_LSB +: 8];
				req_reg.sel <= pwdata[`CMD_SEL_LSB +: 2];
				req_reg.write <= pwdata[`CMD_WRITE_BIT];
				start_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read data and pin sampling
	// ----------------------------------------
	// inputs come synchronous, one stage keeps status reads glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= `BYTE_ZERO;
			rx_n_reg <= 1'b1;
			tx_n_reg <= 1'b1;
			emc_n_reg <= 1'b1;
		end else begin
			if (seq_done && !req_reg.write) begin
				rdata_reg <= seq_rdata;
			end
			rx_n_reg <= rx_char_waiting_n;
			tx_n_reg <= tx_holding_free_n;
			emc_n_reg <= tx_empty_or_modem_change_n;
		end
	end

	// ----------------------------------------
	// device bus cycle engine
	// ----------------------------------------
	bus_cycle_seq u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_reg),
		.req(req_reg),
		.din(dev_data_in),
		.pins(seq_pins),
		.busy(seq_busy),
		.done(seq_done),
		.rdata(seq_rdata)
	);

	// outputs straight from registers
	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign dev_ce_n = seq_pins.ce_n;
	assign dev_rw = seq_pins.rw;
	assign dev_sel = seq_pins.sel;
	assign dev_data_out = seq_pins.dout;
	assign dev_data_oe = seq_pins.doe;
	assign dev_reset = ctrl_reg[`CTRL_RESET_BIT];

endmodule

`default_nettype wire

// file: testbench/usart_dev_model.sv
// Purpose: behavioural serial controller on the host's byte bus
// Assumes: pins sampled on pclk; reset input active high
// Notes: register 3 loops a written byte back as a waiting character
`timescale 1ns/1ps
`default_nettype none

module usart_dev_model (
	input wire logic pclk, // bench clock
	input wire logic reset, // master reset, active high
	input wire logic ce_n, // chip enable, active low
	input wire logic rw, // high writes
	input wire logic [1:0] sel, // register select
	input wire logic [7:0] host_d, // host data drive
	input wire logic host_oe, // host drives data
	input wire logic [1:0] modem_in_n, // bit 0 carrier detect, bit 1 data-set-ready, active low
	output logic [7:0] bus, // resolved data bus
	output logic rx_n, // receive-ready, active low
	output logic txf_n, // transmit-ready, active low
	output logic emp_n // empty/change, active low
);
	logic [7:0] regs [4]; // mode, command, sync/escape and character bytes
	logic [7:0] last;
	logic [1:0] modem_prev;
	// ------------------------------
	// bus resolution
	// ------------------------------
	// undriven bus shows the inverse of the last level, never a stale match
	assign bus = host_oe ? host_d : (!ce_n && !rw) ? regs[sel] : ~last;
	// register file and flags, cleared at once by reset
	always @(posedge pclk or posedge reset) begin
		if (reset) begin
			regs <= '{default: 8'h00};
			rx_n <= 1'b1;
			txf_n <= 1'b0;
			emp_n <= 1'b0; // transmitter starts empty
		end else begin
			if (!ce_n && rw) begin
				regs[sel] <= bus;
				if (sel == 2'h3) begin
					txf_n <= 1'b1; // character taken for sending
					emp_n <= 1'b1;
					rx_n <= 1'b0;
				end
			end else if (!ce_n && sel == 2'h3) begin
				rx_n <= 1'b1;
			end
			// receiver is off without carrier, so nothing can be waiting
			if (modem_in_n[0]) begin
				rx_n <= 1'b1;
			end
			// a modem change wins over a clear in the same cycle
			if (modem_in_n != modem_prev) begin
				emp_n <= 1'b0;
			end
		end
	end
	always @(posedge pclk) begin
		last <= bus;
		modem_prev <= modem_in_n;
	end
endmodule
`default_nettype wire

// file: testbench/usart_host_props.sv
// Purpose: port-level checks of the host bridge
// Assumes: one clock domain, pclk
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none

module usart_host_props (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic pready, // APB ready
	input wire logic [31:0] prdata, // APB read data
	input wire logic pslverr, // APB error
	input wire logic dev_ce_n, // chip enable
	input wire logic dev_rw, // direction
	input wire logic [1:0] dev_sel, // select
	input wire logic dev_data_oe, // data enable
	input wire logic dev_reset // device reset
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------
	// sequences
	// ------------------------------
	sequence strobe_s;
		!dev_ce_n [*5] ##1 dev_ce_n;
	endsequence
	sequence rd_done_s;
		psel && penable && pready && !pwrite;
	endsequence
	chk_strobe_len: assert property ($fell(dev_ce_n) |-> strobe_s) else $error("strobe length off");
	chk_sel_steady: assert property (!dev_ce_n && $past(!dev_ce_n) |-> $stable(dev_sel) && $stable(dev_rw))
		else $error("select moved under strobe");
	chk_oe_write: assert property (dev_data_oe |-> dev_rw) else $error("data driven on a read");
	chk_pready_time: assert property (psel && penable && !pready |=> pready) else $error("ready late");
	chk_pready_pulse: assert property (pready |=> !pready) else $error("ready stuck");
	chk_err_pair: assert property (pslverr |-> pready && paddr > 12'h00C) else $error("error misplaced");
	chk_err_unmapped: assert property (pready && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	chk_status_rst: assert property ((rd_done_s and (paddr == 12'h008)) |-> prdata[4] == dev_reset)
		else $error("status reset bit wrong");
	chk_reset_idle: assert property (dev_reset && dev_ce_n |=> dev_ce_n) else $error("access in reset");
endmodule
bind usart_host_ctrl usart_host_props chk_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pready,
	.prdata, .pslverr, .dev_ce_n, .dev_rw, .dev_sel, .dev_data_oe, .dev_reset);
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the host bridge
// Assumes: device model on the byte bus
// Notes: expected reads queued by the driver, compared by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "usart_host_defs.svh"

module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, ce_n, rw, oe, dreset, rx_n, txf_n, emp_n;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [1:0] sel;
	logic [1:0] modem_n = 2'h0;
	logic er;
	logic [7:0] dout, bus, b;
	logic [32:0] exp_q [$];
	logic [32:0] e;
	int miscompares = 0, total_checks = 0, i, n;
	integer seed = 17529;
	always #25 pclk = ~pclk;
	usart_host_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.dev_ce_n(ce_n), .dev_rw(rw), .dev_sel(sel), .dev_data_out(dout), .dev_data_oe(oe),
		.dev_data_in(bus), .dev_reset(dreset), .rx_char_waiting_n(rx_n), .tx_holding_free_n(txf_n),
		.tx_empty_or_modem_change_n(emp_n));
	usart_dev_model dev (.pclk(pclk), .reset(dreset), .ce_n(ce_n), .rw(rw), .sel(sel), .host_d(dout),
		.host_oe(oe), .modem_in_n(modem_n), .bus(bus), .rx_n(rx_n), .txf_n(txf_n), .emp_n(emp_n));
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ------------------------------
	// APB master
	// ------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// a read whose result is noted for the monitor when u is set
	task rd(input logic [11:0] a, input logic [31:0] x, input logic u);
		exp_q.push_back({u, x});
		apb(1'b0, a, 32'h0);
	endtask
	task wait_idle;
		n = 0;
		do begin rd(`OFS_STATUS, 32'h0, 1'b0); n++; end while (r[0] !== 1'b0 && n < 50);
		if (r[0] !== 1'b0) begin
			miscompares++;
			$display("wrong value at %0t: device access never finished", $time);
		end
	endtask
	// monitor: oldest note against each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[32]) begin
				total_checks++;
				if (prdata !== e[31:0]) begin
					miscompares++;
					$display("wrong value at %0t: addr %h got %h want %h", $time, paddr, prdata, e[31:0]);
				end
			end
		end
	end
	initial begin
		#(50 * 20000);
		miscompares++;
		finish_test();
	end
	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`OFS_CTRL, 32'h1, 1'b1);
		apb(1'b1, `OFS_CMD, 32'h7A5); // dropped while device held in reset
		rd(`OFS_STATUS, 32'h18, 1'b1);
		apb(1'b1, `OFS_CTRL, 32'h2);
		rd(`OFS_STATUS, 32'h2C, 1'b1);
		for (i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			apb(1'b1, `OFS_CMD, {21'h0, 1'b1, i[1:0], b});
			wait_idle();
			if (i == 3) begin
				rd(`OFS_STATUS, 32'h22, 1'b1);
			end
			apb(1'b1, `OFS_CMD, {21'h0, 1'b0, i[1:0], 8'h00});
			wait_idle();
			rd(`OFS_RDATA, {24'h0, b}, 1'b1);
		end
		rd(`OFS_STATUS, 32'h20, 1'b1);
		// carrier lost: change flagged, receiver held off
		modem_n <= 2'h1;
		rd(`OFS_STATUS, 32'h28, 1'b1);
		apb(1'b1, `OFS_CMD, {21'h0, 1'b1, 2'h3, 8'h5A});
		wait_idle();
		rd(`OFS_STATUS, 32'h20, 1'b1);
		modem_n <= 2'h3;
		rd(`OFS_STATUS, 32'h28, 1'b1);
		rd(`OFS_CMD, 32'h0, 1'b1);
		rd(12'h010, 32'h0, 1'b1);
		total_checks++;
		if (er !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: unmapped address not refused", $time);
		end
		repeat (2) @(posedge pclk);
		finish_test();
	end
endmodule
`default_nettype wire
